// >>> shared/wwdt_pkg.sv
// window watchdog timing constants: times, derived cycle counts, pin modes
// assumes a 40 MHz block clock
package wwdt_pkg;

  // ************************************************
  // clock
  // ************************************************
  localparam int unsigned CLK_PERIOD_NS = 25;

  // ************************************************
  // window timing pin modes
  // ************************************************
  localparam logic [1:0] PIN_OPEN = 2'h0;
  localparam logic [1:0] PIN_PULLUP = 2'h1;
  localparam logic [1:0] PIN_CAP = 2'h2;

  // ************************************************
  // fixed windows, typical
  // ************************************************
  localparam longint unsigned OPEN_LOWER_US = 800000;
  localparam longint unsigned OPEN_UPPER_US = 1600000;
  localparam longint unsigned PULLUP_LOWER_NS = 1850000;
  localparam longint unsigned PULLUP_UPPER_NS = 11000000;

  localparam logic [31:0] OPEN_LOWER_CYC = 32'((OPEN_LOWER_US * 1000) / CLK_PERIOD_NS);
  localparam logic [31:0] OPEN_UPPER_CYC = 32'((OPEN_UPPER_US * 1000) / CLK_PERIOD_NS);
  localparam logic [31:0] PULLUP_LOWER_CYC = 32'(PULLUP_LOWER_NS / CLK_PERIOD_NS);
  localparam logic [31:0] PULLUP_UPPER_CYC = 32'(PULLUP_UPPER_NS / CLK_PERIOD_NS);

  // ************************************************
  // capacitor mode: upper = slope * c + offset
  // ************************************************
  localparam longint unsigned CAP_SLOPE_NS_PER_PF = 77400;
  localparam longint unsigned CAP_OFFSET_NS = 55000000;
  localparam logic [31:0] CAP_SLOPE_CYC = 32'(CAP_SLOPE_NS_PER_PF / CLK_PERIOD_NS);
  localparam logic [31:0] CAP_OFFSET_CYC = 32'(CAP_OFFSET_NS / CLK_PERIOD_NS);
  localparam logic [19:0] CAP_MIN_PF = 20'h00064;
  localparam logic [19:0] CAP_MAX_PF = 20'hf4240;

  localparam logic [31:0] CNT_ZERO = 32'h00000000;
  localparam logic [31:0] CNT_ONE = 32'h00000001;

  // ************************************************
  // states
  // ************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FIRST = 3'b010,
    ST_WINDOW = 3'b100
  } wwdt_state_t;

endpackage : wwdt_pkg

// >>> verilog/wwdt_top.sv
// window watchdog timing block: kick window check driving an open-drain fault
// assumes all inputs synchronous to CLOCK_I; pin mode and capacitor value
// come from an analog front end that classifies the timing pin
// pin mode 3 is treated as open
`timescale 1ns/1ps

module wwdt_top #(
  parameter logic [31:0] OPEN_LOWER_CYC = wwdt_pkg::OPEN_LOWER_CYC,
  parameter logic [31:0] OPEN_UPPER_CYC = wwdt_pkg::OPEN_UPPER_CYC,
  parameter logic [31:0] PULLUP_LOWER_CYC = wwdt_pkg::PULLUP_LOWER_CYC,
  parameter logic [31:0] PULLUP_UPPER_CYC = wwdt_pkg::PULLUP_UPPER_CYC,
  parameter logic [31:0] CAP_OFFSET_CYC = wwdt_pkg::CAP_OFFSET_CYC
) (
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  input wire logic SUPERVISOR_RESET_N_I,
  input wire logic WATCHDOG_ENABLE_INPUT_I,
  input wire logic KICK_INPUT_I,
  input wire logic [1:0] WINDOW_TIMING_PIN_MODE_I,
  input wire logic [19:0] TIMING_CAPACITOR_PF_I,
  output logic WATCHDOG_FAULT_OUTPUT_O,
  output logic WATCHDOG_FAULT_OUTPUT_OE_O
);

  // ************************************************
  // capacitor clamp and derived upper bound
  // ************************************************
  logic [19:0] cap_pf;
  logic [31:0] cap_upper;

  // out-of-range capacitors pinned to the nearest supported value
  always_comb
  begin
    cap_pf = TIMING_CAPACITOR_PF_I;
    if (cap_pf < wwdt_pkg::CAP_MIN_PF)
    begin
      cap_pf = wwdt_pkg::CAP_MIN_PF;
    end
    else if (cap_pf > wwdt_pkg::CAP_MAX_PF)
    begin
      cap_pf = wwdt_pkg::CAP_MAX_PF;
    end
    cap_upper = 32'(wwdt_pkg::CAP_SLOPE_CYC * {12'h000, cap_pf}) + CAP_OFFSET_CYC;
  end

  // ************************************************
  // window bounds
  // ************************************************
  logic [31:0] upper_window_bound;
  logic [31:0] lower_window_bound;

  // bounds follow the pin mode live: a mode change acts at once
  always_comb
  begin
    case (WINDOW_TIMING_PIN_MODE_I)
      wwdt_pkg::PIN_CAP:
      begin
        upper_window_bound = cap_upper;
        lower_window_bound = {1'b0, cap_upper[31:1]};
      end
      wwdt_pkg::PIN_PULLUP:
      begin
        upper_window_bound = PULLUP_UPPER_CYC;
        lower_window_bound = PULLUP_LOWER_CYC;
      end
      default:
      begin
        upper_window_bound = OPEN_UPPER_CYC;
        lower_window_bound = OPEN_LOWER_CYC;
      end
    endcase
  end

  // ************************************************
  // kick edge and window state
  // ************************************************
  wwdt_pkg::wwdt_state_t state_r;
  wwdt_pkg::wwdt_state_t state_nxt;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic kick_d_r;
  logic kick_d_nxt;
  logic fault_r;
  logic fault_nxt;
  logic active;
  // high for one cycle on a sampled 1-to-0 step of the kick
  logic kick_fall;
  logic expired;

  always_comb
  begin
    // kicks are seen only while the watchdog is live
    active = SUPERVISOR_RESET_N_I & WATCHDOG_ENABLE_INPUT_I;
    kick_d_nxt = KICK_INPUT_I;
    kick_fall = kick_d_r & ~KICK_INPUT_I;
    // a kick and an expiry in one cycle: the kick wins
    expired = (cnt_r + wwdt_pkg::CNT_ONE) >= upper_window_bound;
    state_nxt = state_r;
    cnt_nxt = cnt_r + wwdt_pkg::CNT_ONE;
    fault_nxt = fault_r;
    // disable or supervisor reset releases the pin and parks the window
    if (!active)
    begin
      state_nxt = wwdt_pkg::ST_IDLE;
      cnt_nxt = wwdt_pkg::CNT_ZERO;
      fault_nxt = 1'b0;
    end
    else
    begin
      case (state_r)
        // one cycle here clears the count before the first window
        wwdt_pkg::ST_IDLE:
        begin
          state_nxt = wwdt_pkg::ST_FIRST;
          cnt_nxt = wwdt_pkg::CNT_ZERO;
        end
        // first kick: no lower bound check
        wwdt_pkg::ST_FIRST:
        begin
          if (kick_fall)
          begin
            state_nxt = wwdt_pkg::ST_WINDOW;
            cnt_nxt = wwdt_pkg::CNT_ZERO;
          end
          else if (expired)
          begin
            fault_nxt = 1'b1;
            state_nxt = wwdt_pkg::ST_WINDOW;
            cnt_nxt = wwdt_pkg::CNT_ZERO;
          end
        end
        // fault latches; the window keeps running after it
        wwdt_pkg::ST_WINDOW:
        begin
          if (kick_fall)
          begin
            if (cnt_r < lower_window_bound)
            begin
              fault_nxt = 1'b1;
            end
            cnt_nxt = wwdt_pkg::CNT_ZERO;
          end
          else if (expired)
          begin
            fault_nxt = 1'b1;
            cnt_nxt = wwdt_pkg::CNT_ZERO;
          end
        end
        default:
        begin
          state_nxt = wwdt_pkg::ST_IDLE;
          cnt_nxt = wwdt_pkg::CNT_ZERO;
          fault_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      state_r <= wwdt_pkg::ST_IDLE;
      cnt_r <= wwdt_pkg::CNT_ZERO;
      // idle kick level is high, so low here cannot fake a fall
      kick_d_r <= 1'b0;
      fault_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      kick_d_r <= kick_d_nxt;
      fault_r <= fault_nxt;
    end
  end

  // ************************************************
  // open-drain fault pin: drives low only on fault
  // ************************************************
  // data fixed low; the enable alone drives or releases the pin
  logic pin_oe_r;
  logic pin_oe_nxt;

  always_comb
  begin
    pin_oe_nxt = fault_nxt;
  end

  always_ff @(posedge CLOCK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      pin_oe_r <= 1'b0;
      WATCHDOG_FAULT_OUTPUT_O <= 1'b0;
    end
    else
    begin
      pin_oe_r <= pin_oe_nxt;
      WATCHDOG_FAULT_OUTPUT_O <= 1'b0;
    end
  end

  // enable flop feeds the pin directly
  assign WATCHDOG_FAULT_OUTPUT_OE_O = pin_oe_r;

endmodule : wwdt_top

// >>> verif/wwdt_top_chk.sv
// checker for the window watchdog: fault pin against kicks, enable, supervisor reset
// assumes wwdt_top runs with the bench's small window parameters, mirrored here
`timescale 1ns/1ps
module wwdt_top_chk #(
  parameter logic [31:0] OPEN_LOWER_CYC = 32'h14,
  parameter logic [31:0] OPEN_UPPER_CYC = 32'h28,
  parameter logic [31:0] PULLUP_LOWER_CYC = 32'h1e,
  parameter logic [31:0] PULLUP_UPPER_CYC = 32'h3c
) (
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  input wire logic SUPERVISOR_RESET_N_I,
  input wire logic WATCHDOG_ENABLE_INPUT_I,
  input wire logic KICK_INPUT_I,
  input wire logic [1:0] WINDOW_TIMING_PIN_MODE_I,
  input wire logic WATCHDOG_FAULT_OUTPUT_O,
  input wire logic WATCHDOG_FAULT_OUTPUT_OE_O
);
  logic kprev_r, act_r, first_r, act, kick, fixed, oe;
  logic [31:0] cnt_r, lo, hi;
  assign oe = WATCHDOG_FAULT_OUTPUT_OE_O;
  assign act = SUPERVISOR_RESET_N_I && WATCHDOG_ENABLE_INPUT_I;
  // the design ignores a kick in its first live cycle
  assign kick = act && act_r && kprev_r && !KICK_INPUT_I;
  assign fixed = WINDOW_TIMING_PIN_MODE_I != wwdt_pkg::PIN_CAP;
  assign lo = (WINDOW_TIMING_PIN_MODE_I == wwdt_pkg::PIN_PULLUP) ? PULLUP_LOWER_CYC : OPEN_LOWER_CYC;
  assign hi = (WINDOW_TIMING_PIN_MODE_I == wwdt_pkg::PIN_PULLUP) ? PULLUP_UPPER_CYC : OPEN_UPPER_CYC;
  // cycles since activation or last kick
  always_ff @(posedge CLOCK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      kprev_r <= 1'b0;
      act_r <= 1'b0;
      first_r <= 1'b1;
      cnt_r <= 32'h0;
    end
    else
    begin
      kprev_r <= KICK_INPUT_I;
      act_r <= act;
      first_r <= !act || (first_r && !kick);
      cnt_r <= (!act || kick) ? 32'h0 : cnt_r + 32'h1;
    end
  end
  // ************************************************
  // assertions
  // ************************************************
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence s_early;
    kick && !first_r && fixed && (cnt_r + 32'h2 < lo);
  endsequence
  AST_SUP_REL: assert property (!SUPERVISOR_RESET_N_I |=> !oe)
    else $error("fault kept during supervisor reset");
  AST_EN_OFF: assert property (!WATCHDOG_ENABLE_INPUT_I |=> !oe)
    else $error("fault kept while disabled");
  AST_EN_QUIET: assert property ($fell(WATCHDOG_ENABLE_INPUT_I) |-> ##1 !oe [*2])
    else $error("fault while disabled");
  AST_DRIVE_LOW: assert property (oe |-> !WATCHDOG_FAULT_OUTPUT_O)
    else $error("fault pin not driven low");
  AST_LATCH: assert property (oe && act |=> oe)
    else $error("fault dropped while active");
  AST_LATE: assert property (
    act && fixed && cnt_r > hi + 32'h2 |-> oe)
    else $error("missing kick not flagged");
  AST_EARLY: assert property (s_early |=> oe)
    else $error("early kick not flagged");
  AST_QUIET: assert property (!oe && act && fixed && cnt_r + 32'h2 < hi &&
    !(kick && !first_r && cnt_r < lo + 32'h2) |=> !oe) else $error("spurious fault");
endmodule : wwdt_top_chk
bind wwdt_top wwdt_top_chk u_chk (.*);

// >>> verif/wwdt_mcu_model.sv
// supervised processor model: issues falling-edge kicks on request
// assumes calls from the bench at falling clock edges
`timescale 1ns/1ps
module wwdt_mcu_model (
  input wire logic clk_i,
  output logic kick_o
);
  initial kick_o = 1'b1;
  // one kick after n idle cycles
  task automatic pulse(input int n);
    repeat (n) @(negedge clk_i);
    kick_o = 1'b0;
    @(negedge clk_i);
    kick_o = 1'b1;
  endtask : pulse
endmodule : wwdt_mcu_model

// >>> verif/testbench.sv
// self-checking bench for the window watchdog
// assumes small window parameters: lower 20/30, upper 40/60 cycles
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, rst_n = 1'b0, sup_n = 1'b0, en = 1'b0, oe, o, kick;
  logic [1:0] mode = 2'h0;
  logic [1:0] modes [3] = '{2'h0, 2'h1, 2'h3};
  logic [19:0] cap = 20'h00064;
  int miscompares = 0, comparisons = 0, cycles = 0, lo;
  always #12.5 clk = ~clk;
  wwdt_mcu_model mcu (.clk_i(clk), .kick_o(kick));
  wwdt_top #(.OPEN_LOWER_CYC(32'h14), .OPEN_UPPER_CYC(32'h28), .PULLUP_LOWER_CYC(32'h1e),
    .PULLUP_UPPER_CYC(32'h3c), .CAP_OFFSET_CYC(32'h64)) DUT (.CLOCK_I(clk), .RESET_N_I(rst_n),
    .SUPERVISOR_RESET_N_I(sup_n), .WATCHDOG_ENABLE_INPUT_I(en), .KICK_INPUT_I(kick),
    .WINDOW_TIMING_PIN_MODE_I(mode), .TIMING_CAPACITOR_PF_I(cap),
    .WATCHDOG_FAULT_OUTPUT_O(o), .WATCHDOG_FAULT_OUTPUT_OE_O(oe));
  task automatic chk(input string what, input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %b seen %b", what, exp, seen);
    end
  endtask : chk
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      results();
    end
  end
  // ************************************************
  // scenarios
  // ************************************************
  task automatic restart(input logic [1:0] m);
    @(negedge clk);
    {en, sup_n, mode} = {2'b01, m};
    lo = (m == wwdt_pkg::PIN_PULLUP) ? 30 : 20;
    @(negedge clk);
    chk("fault off", oe, 1'b0);
    en = 1'b1;
  endtask : restart
  task automatic t_late(input logic [1:0] m);
    restart(m);
    repeat (2 * lo - 4) @(negedge clk);
    chk("fault early", oe, 1'b0);
    repeat (8) @(negedge clk);
    chk("fault late", oe, 1'b1);
    chk("fault level", o, 1'b0);
    sup_n = 1'b0;
    repeat (3) mcu.pulse(1);
    repeat (90) @(negedge clk);
    chk("fault released", oe, 1'b0);
  endtask : t_late
  task automatic t_window(input logic [1:0] m);
    restart(m);
    mcu.pulse(2 * lo - 6);
    chk("first kick", oe, 1'b0);
    mcu.pulse(lo + 4);
    mcu.pulse(2 * lo - 6);
    chk("kicks in window", oe, 1'b0);
    mcu.pulse(3);
    @(negedge clk);
    chk("kick too early", oe, 1'b1);
  endtask : t_window
  task automatic t_disabled();
    restart(wwdt_pkg::PIN_OPEN);
    @(negedge clk);
    en = 1'b0;
    repeat (3) mcu.pulse(1);
    repeat (100) @(negedge clk);
    chk("disabled", oe, 1'b0);
  endtask : t_disabled
  task automatic t_cap(input logic [19:0] c);
    cap = c;
    restart(wwdt_pkg::PIN_CAP);
    mcu.pulse(10);
    chk("cap first kick", oe, 1'b0);
    mcu.pulse(50);
    chk("cap early kick", oe, 1'b1);
  endtask : t_cap
  initial
  begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    chk("reset", oe, 1'b0);
    foreach (modes[i])
    begin
      t_late(modes[i]);
      t_window(modes[i]);
    end
    t_disabled();
    t_cap(20'h00000);
    t_cap(20'hfffff);
    results();
  end
endmodule : testbench
